/* hw/buck1_regs_pkg.sv */
/*
  Constants and carrier types for the first buck converter control register bank.
  Assumes a classic Wishbone slave with 32-bit data and a 50 MHz clock.
*/
package buck1_regs_pkg;

  // ------------------------------------------------------------
  // Register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [15:0] FAULT_HWC_INDEX = 16'h4057;
  localparam logic [15:0] ON_CONFIG_INDEX = 16'h4058;
  localparam logic [15:0] SLEEP_VOLT_INDEX = 16'h4059;
  localparam logic [15:0] IRQ_STATUS_INDEX = 16'h4060;
  localparam logic [15:0] IRQ_MASK_INDEX = 16'h4061;
  localparam logic [15:0] FREQ_INDEX = 16'h4062;
  localparam logic [17:0] FAULT_HWC_ADDR = {FAULT_HWC_INDEX, 2'b00};
  localparam logic [17:0] ON_CONFIG_ADDR = {ON_CONFIG_INDEX, 2'b00};
  localparam logic [17:0] SLEEP_VOLT_ADDR = {SLEEP_VOLT_INDEX, 2'b00};
  localparam logic [17:0] IRQ_STATUS_ADDR = {IRQ_STATUS_INDEX, 2'b00};
  localparam logic [17:0] IRQ_MASK_ADDR = {IRQ_MASK_INDEX, 2'b00};
  localparam logic [17:0] FREQ_ADDR = {FREQ_INDEX, 2'b00};

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ERR_ACT_LSB = 14;
  localparam int HWC_SRC_LSB = 11;
  localparam int HWC_VSEL_BIT = 10;
  localparam int MODE_LSB = 8;
  localparam int HC_THR_LSB = 4;
  localparam int HC_ENA_BIT = 0;
  localparam int ON_SLOT_LSB = 13;
  localparam int VOLT_UPPER_LSB = 2;

  // ------------------------------------------------------------
  // Reset values and write masks
  // ------------------------------------------------------------
  localparam logic [15:0] FAULT_HWC_RESET = 16'h0300;
  localparam logic [15:0] ON_CONFIG_RESET = 16'h0100;
  localparam logic [6:0] SLEEP_VOLT_RESET = 7'h00;
  localparam logic [1:0] FREQ_RESET = 2'h0;
  localparam logic [15:0] FAULT_HWC_WMASK = 16'hDF71;
  localparam logic [15:0] ON_CONFIG_WMASK = 16'hE37F;

  // ------------------------------------------------------------
  // Voltage code limits and threshold step
  // ------------------------------------------------------------
  localparam logic [6:0] VCODE_MIN = 7'h08;
  localparam logic [6:0] VCODE_MAX = 7'h67;
  localparam logic [6:0] VCODE_4MHZ_MAX = 7'h48;
  localparam int HC_STEP_MA = 250;

  typedef enum logic [1:0] {
    ERR_IGNORE = 2'b00,
    ERR_CONV_OFF = 2'b01,
    ERR_SYS_RESET = 2'b10,
    ERR_RESERVED = 2'b11
  } err_action_t;

  typedef enum logic [1:0] {
    HWC_OFF = 2'b00,
    HWC_IN1 = 2'b01,
    HWC_IN2 = 2'b10,
    HWC_EITHER = 2'b11
  } hwc_source_t;

  typedef enum logic [1:0] {
    MODE_FCCM = 2'b00,
    MODE_AUTO_OR_OFF = 2'b01,
    MODE_LDO = 2'b10,
    MODE_HYST = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    FREQ_RES0 = 2'b00,
    FREQ_2MHZ = 2'b01,
    FREQ_4MHZ = 2'b10,
    FREQ_RES3 = 2'b11
  } freq_sel_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [17:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic enable;
    op_mode_t mode;
    logic [6:0] voltageCode;
    logic [2:0] highCurrentThreshold;
    logic highCurrentDetectEnable;
    logic [11:0] highCurrentThresholdMa;
  } conv_ctrl_t;

endpackage : buck1_regs_pkg

/* hw/buck1_hw_control_on_config_regs.sv */
/*
  Register bank and control steering for the first buck converter.
  Assumes the sequencer, hardware control pins and converter status come from
  the same clock domain except the hardware pins, which are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module buck1_hw_control_on_config_regs
  import buck1_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire buck1_regs_pkg::wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic bootLoad,
  input wire logic [4:0] bootVoltageUpper,
  input wire logic [1:0] bootFrequency,
  input wire logic hwControlIn1,
  input wire logic hwControlIn2,
  input wire logic hwEnableIn1,
  input wire logic hwEnableIn2,
  input wire logic [2:0] sequencerSlot,
  input wire logic undervoltageEvent,
  input wire logic highCurrentEvent,
  output buck1_regs_pkg::conv_ctrl_t convCtrl,
  output logic converterShutdown,
  output logic systemResetReq,
  output buck1_regs_pkg::freq_sel_t switchingFrequency,
  output logic irq
);
  import buck1_regs_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] clampCode(input logic [6:0] code);
    if (code < VCODE_MIN)
    begin
      clampCode = VCODE_MIN;
    end
    else if (code > VCODE_MAX)
    begin
      clampCode = VCODE_MAX;
    end
    else
    begin
      clampCode = code;
    end
  endfunction : clampCode

  function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel, input logic [15:0] wmask);
    logic [15:0] byteMask;
    byteMask = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    mergeWrite = (old & ~byteMask) | (dat[15:0] & byteMask);
  endfunction : mergeWrite

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] faultHwc_ff;
  logic [15:0] onConfig_ff;
  logic [6:0] sleepVolt_ff;
  logic [1:0] irqStatus_ff;
  logic [1:0] irqMask_ff;
  logic [1:0] freq_ff;
  logic ack_ff;
  logic [31:0] rdData_ff;
  logic shutdown_ff;
  logic sysReset_ff;
  conv_ctrl_t ctrl_ff;
  logic [2:0] pinSync1_ff [4];
  logic [3:0] pinStable_ff;

  logic access;
  logic writeStb;
  logic [31:0] nxt_rdData;
  err_action_t errAction;
  hwc_source_t hwcSource;
  logic hwcActive;
  logic [2:0] onSlot;
  logic nxt_enable;
  conv_ctrl_t nxt_ctrl;

  assign access = wbReq.cyc && wbReq.stb && !ack_ff;
  assign writeStb = access && wbReq.we;
  assign errAction = err_action_t'(faultHwc_ff[ERR_ACT_LSB +: 2]);
  assign hwcSource = hwc_source_t'(faultHwc_ff[HWC_SRC_LSB +: 2]);
  assign onSlot = onConfig_ff[ON_SLOT_LSB +: 3];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Three stages; a level is taken only once stages two and three agree
  logic [3:0] pinRaw;
  assign pinRaw = {hwEnableIn2, hwEnableIn1, hwControlIn2, hwControlIn1};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pinSync1_ff[gi] <= 3'b000;
          pinStable_ff[gi] <= 1'b0;
        end
        else
        begin
          pinSync1_ff[gi] <= {pinSync1_ff[gi][1:0], pinRaw[gi]};
          if (pinSync1_ff[gi][1] == pinSync1_ff[gi][2])
          begin
            pinStable_ff[gi] <= pinSync1_ff[gi][2];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Wishbone slave: one wait-free ack a cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= access;
    end
  end

  always_comb
  begin
    nxt_rdData = 32'h0000_0000;
    case (wbReq.adr)
      FAULT_HWC_ADDR: nxt_rdData = {16'h0000, faultHwc_ff};
      ON_CONFIG_ADDR: nxt_rdData = {16'h0000, onConfig_ff};
      SLEEP_VOLT_ADDR: nxt_rdData = {25'h0, sleepVolt_ff};
      IRQ_STATUS_ADDR: nxt_rdData = {30'h0, irqStatus_ff};
      IRQ_MASK_ADDR: nxt_rdData = {30'h0, irqMask_ff};
      FREQ_ADDR: nxt_rdData = {30'h0, freq_ff};
      default: nxt_rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdData_ff <= 32'h0000_0000;
    end
    else if (access && !wbReq.we)
    begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign wbDatOut = rdData_ff;
  assign wbAck = ack_ff;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultHwc_ff <= FAULT_HWC_RESET;
    end
    else if (writeStb && wbReq.adr == FAULT_HWC_ADDR)
    begin
      faultHwc_ff <= mergeWrite(faultHwc_ff, wbReq.dat, wbReq.sel, FAULT_HWC_WMASK);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      onConfig_ff <= ON_CONFIG_RESET;
    end
    else if (bootLoad)
    begin
      // Only the upper voltage bits survive in boot memory
      onConfig_ff[6:0] <= {bootVoltageUpper, 2'b00};
    end
    else if (writeStb && wbReq.adr == ON_CONFIG_ADDR)
    begin
      onConfig_ff <= mergeWrite(onConfig_ff, wbReq.dat, wbReq.sel, ON_CONFIG_WMASK);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleepVolt_ff <= SLEEP_VOLT_RESET;
    end
    else if (writeStb && wbReq.adr == SLEEP_VOLT_ADDR && wbReq.sel[0])
    begin
      sleepVolt_ff <= wbReq.dat[6:0];
    end
  end

  // Bus writes are ignored here: only the boot load may set the frequency
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      freq_ff <= FREQ_RESET;
    end
    else if (bootLoad)
    begin
      freq_ff <= bootFrequency;
    end
  end
  assign switchingFrequency = freq_sel_t'(freq_ff);

  // ------------------------------------------------------------
  // Interrupts: bit 0 undervoltage, bit 1 high current
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqMask_ff <= 2'b00;
    end
    else if (writeStb && wbReq.adr == IRQ_MASK_ADDR && wbReq.sel[0])
    begin
      irqMask_ff <= wbReq.dat[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqStatus_ff <= 2'b00;
    end
    else
    begin
      // Set beats a same-cycle write-one-to-clear
      irqStatus_ff <= (irqStatus_ff
                       & ~((writeStb && wbReq.adr == IRQ_STATUS_ADDR && wbReq.sel[0])
                           ? wbReq.dat[1:0] : 2'b00))
                      | {highCurrentEvent && faultHwc_ff[HC_ENA_BIT],
                         undervoltageEvent};
    end
  end
  // A set mask bit hides its event; after reset only undervoltage events reach the pin
  assign irq = |(irqStatus_ff & ~irqMask_ff);

  // ------------------------------------------------------------
  // Undervoltage action
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shutdown_ff <= 1'b0;
      sysReset_ff <= 1'b0;
    end
    else
    begin
      sysReset_ff <= undervoltageEvent && errAction == ERR_SYS_RESET;
      if (undervoltageEvent)
      begin
        case (errAction)
          ERR_CONV_OFF: shutdown_ff <= 1'b1;
          ERR_IGNORE, ERR_RESERVED: shutdown_ff <= shutdown_ff;
          default: shutdown_ff <= shutdown_ff;
        endcase
      end
      else if (writeStb && wbReq.adr == IRQ_STATUS_ADDR && wbReq.sel[0] && wbReq.dat[0])
      begin
        // Clearing the undervoltage flag releases the latched shutdown
        shutdown_ff <= 1'b0;
      end
    end
  end
  assign converterShutdown = shutdown_ff;
  assign systemResetReq = sysReset_ff;

  // ------------------------------------------------------------
  // Converter steering
  // ------------------------------------------------------------
  always_comb
  begin
    case (hwcSource)
      HWC_IN1: hwcActive = pinStable_ff[0];
      HWC_IN2: hwcActive = pinStable_ff[1];
      HWC_EITHER: hwcActive = pinStable_ff[0] || pinStable_ff[1];
      default: hwcActive = 1'b0;
    endcase
  end

  always_comb
  begin
    case (onSlot)
      3'b000: nxt_enable = 1'b0;
      3'b110: nxt_enable = pinStable_ff[2];
      3'b111: nxt_enable = pinStable_ff[3];
      default: nxt_enable = (sequencerSlot != 3'b000) && (sequencerSlot >= onSlot);
    endcase
  end

  always_comb
  begin
    nxt_ctrl = '0;
    nxt_ctrl.highCurrentDetectEnable = faultHwc_ff[HC_ENA_BIT];
    nxt_ctrl.highCurrentThreshold = faultHwc_ff[HC_THR_LSB +: 3];
    nxt_ctrl.highCurrentThresholdMa = 12'((faultHwc_ff[HC_THR_LSB +: 3] + 1) * HC_STEP_MA);
    if (hwcActive)
    begin
      nxt_ctrl.mode = op_mode_t'(faultHwc_ff[MODE_LSB +: 2]);
      nxt_ctrl.enable = nxt_enable && nxt_ctrl.mode != MODE_AUTO_OR_OFF && !shutdown_ff;
      nxt_ctrl.voltageCode = clampCode(faultHwc_ff[HWC_VSEL_BIT] ? sleepVolt_ff
                                                                 : onConfig_ff[6:0]);
    end
    else
    begin
      nxt_ctrl.mode = op_mode_t'(onConfig_ff[MODE_LSB +: 2]);
      nxt_ctrl.enable = nxt_enable && !shutdown_ff;
      nxt_ctrl.voltageCode = clampCode(onConfig_ff[6:0]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end
  assign convCtrl = ctrl_ff;

endmodule : buck1_hw_control_on_config_regs
`default_nettype wire

/* sim/buck1_hw_control_on_config_regs_monitor.sv */
/*
  Concurrent checks on the ports of the buck converter register bank.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module buck1_hw_control_on_config_regs_monitor
  import buck1_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire buck1_regs_pkg::wb_req_t wbReq,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  input wire logic bootLoad,
  input wire logic undervoltageEvent,
  input wire logic highCurrentEvent,
  input wire buck1_regs_pkg::conv_ctrl_t convCtrl,
  input wire logic converterShutdown,
  input wire logic systemResetReq,
  input wire buck1_regs_pkg::freq_sel_t switchingFrequency,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  sequence s_ack_pulse;
    wbAck ##1 !wbAck;
  endsequence
  // Control outputs only mean something once reset has left the pipeline
  sequence s_settled;
    !$past(rst) && !$past(rst, 2);
  endsequence

  property p_ack;
    s_take |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  property p_ack_cause;
    wbAck |-> $past(wbReq.cyc && wbReq.stb && !wbAck);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_thr_ma;
    s_settled |-> convCtrl.highCurrentThresholdMa ==
      (12'(convCtrl.highCurrentThreshold) + 12'h001) * 12'h0FA;
  endproperty
  a_thr_ma: assert property (p_thr_ma) else $error("threshold current wrong");
  property p_clamp;
    s_settled |-> convCtrl.voltageCode inside {[7'h08:7'h67]};
  endproperty
  a_clamp: assert property (p_clamp) else $error("voltage code not clamped");
  property p_sys_cause;
    systemResetReq |-> $past(undervoltageEvent);
  endproperty
  a_sys_cause: assert property (p_sys_cause) else $error("reset request uncaused");
  property p_off_cause;
    $rose(converterShutdown) |-> $past(undervoltageEvent) || $past(undervoltageEvent, 2);
  endproperty
  a_off_cause: assert property (p_off_cause) else $error("shutdown uncaused");
  property p_irq_cause;
    $rose(irq) |-> $past(undervoltageEvent || highCurrentEvent
                         || (wbReq.cyc && wbReq.stb && wbReq.we));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq uncaused");
  property p_freq_hold;
    !$past(rst) && !$stable(switchingFrequency) |-> $past(bootLoad);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency changed by bus");
  property p_dat_hold;
    !$past(rst) && !$stable(wbDatOut) |-> wbAck;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
endmodule : buck1_hw_control_on_config_regs_monitor
`default_nettype wire

/* sim/buck1_hw_control_on_config_regs_bench.sv */
/*
  Self-checking bench for the buck converter register bank.
  Assumes mask bit set means masked and byte addresses from the package.
*/
`timescale 1ns/1ns
`default_nettype none
module buck1_hw_control_on_config_regs_bench;
  import buck1_regs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wb_req_t wbReq;
  logic [31:0] wbDatOut, rd;
  logic wbAck, bootLoad, hwControlIn1, hwControlIn2, hwEnableIn1, hwEnableIn2;
  logic [4:0] bootVoltageUpper;
  logic [1:0] bootFrequency;
  logic [2:0] sequencerSlot, q;
  logic undervoltageEvent, highCurrentEvent, converterShutdown, systemResetReq, irq, en;
  conv_ctrl_t convCtrl;
  freq_sel_t switchingFrequency;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] r = 16'h0024;
  logic [15:0] v;
  logic [6:0] corner [8] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7F, 7'h01};

  buck1_hw_control_on_config_regs buck1_hw_control_on_config_regs_i (.clk, .rst, .wbReq,
    .wbDatOut, .wbAck, .bootLoad, .bootVoltageUpper, .bootFrequency, .hwControlIn1,
    .hwControlIn2, .hwEnableIn1, .hwEnableIn2, .sequencerSlot, .undervoltageEvent,
    .highCurrentEvent, .convCtrl, .converterShutdown, .systemResetReq,
    .switchingFrequency, .irq);

  always #10 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [6:0] clampv(input logic [6:0] c);
    return (c < 7'h08) ? 7'h08 : (c > 7'h67) ? 7'h67 : c;
  endfunction : clampv

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // Called right after an edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] d);
    wbReq <= '{1'b1, 1'b1, w, 4'h3, a, {16'h0000, d}};
    do
    begin
      @(posedge clk);
    end
    while (wbAck !== 1'b1);
    chk(wbAck, 1, "no ack");
    rd = wbDatOut;
    wbReq <= '0;
    @(posedge clk);
  endtask : bus

  task results;
    $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Timeout: the whole run needs under a thousand cycles
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    wbReq = '0;
    {bootLoad, hwControlIn1, hwControlIn2, hwEnableIn1, hwEnableIn2} = 5'h00;
    {bootVoltageUpper, bootFrequency, sequencerSlot} = 10'h000;
    {undervoltageEvent, highCurrentEvent} = 2'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, FAULT_HWC_ADDR, 0);
    chk(rd, 32'h0300, "fault reg reset");
    bus(0, ON_CONFIG_ADDR, 0);
    chk(rd, 32'h0100, "on reg reset");
    bus(1, 18'h3FFFC, 16'hFFFF);
    bus(0, 18'h3FFFC, 0);
    chk(rd, 0, "unmapped read");
    bus(1, FREQ_ADDR, 16'h0002);
    bus(0, FREQ_ADDR, 0);
    chk(rd, 0, "frequency bus write");
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      v = {r[15:13], 2'b00, r[10:7], i[2:0], r[3:0]};
      bus(1, FAULT_HWC_ADDR, v);
      bus(0, FAULT_HWC_ADDR, 0);
      chk(rd, v & FAULT_HWC_WMASK, "fault reg readback");
      chk(convCtrl.highCurrentThreshold, i, "threshold code");
      chk(convCtrl.highCurrentThresholdMa, i * 250 + 250, "threshold current");
      chk(convCtrl.highCurrentDetectEnable, v[0], "detect enable");
      v = {r[8:0], corner[i]};
      bus(1, ON_CONFIG_ADDR, v);
      bus(0, ON_CONFIG_ADDR, 0);
      chk(rd, v & ON_CONFIG_WMASK, "on reg readback");
      chk(convCtrl.voltageCode, clampv(corner[i]), "voltage code");
    end
    $display("test registers done");
    hwEnableIn1 <= 1'b1;
    bus(1, SLEEP_VOLT_ADDR, 16'h0030);
    bus(1, ON_CONFIG_ADDR, 16'hC050);
    for (int s = 0; s < 16; s++)
    begin
      hwControlIn1 <= s[2];
      hwControlIn2 <= s[3];
      bus(1, FAULT_HWC_ADDR, {3'b000, s[1:0], 11'h700});
      repeat (6) @(posedge clk);
      en = (s[0] & s[2]) | (s[1] & s[3]);
      chk(convCtrl.voltageCode, en ? 7'h30 : 7'h50, "hw voltage");
      chk(convCtrl.mode, en ? 2'b11 : 2'b00, "hw mode");
    end
    bus(1, FAULT_HWC_ADDR, 16'h0900);
    repeat (3) @(posedge clk);
    chk(convCtrl.enable, 0, "hw disabled mode");
    bus(1, FAULT_HWC_ADDR, 16'h0000);
    $display("test hardware control done");
    for (int i = 0; i < 32; i++)
    begin
      r = lfsr(r);
      q = r[2:0] % 3'h6;
      sequencerSlot <= q;
      hwEnableIn1 <= r[3];
      hwEnableIn2 <= r[4];
      bus(1, ON_CONFIG_ADDR, {i[2:0], 3'b000, i[4:3], 8'h50});
      repeat (6) @(posedge clk);
      en = (i[2:0] == 6) ? r[3] : (i[2:0] == 7) ? r[4] : (i[2:0] != 0 && q >= i[2:0]);
      chk(convCtrl.enable, en, "slot enable");
      if (en)
        chk(convCtrl.mode, i[4:3], "on mode");
    end
    $display("test slots done");
    for (int a = 0; a < 8; a++)
    begin
      bus(1, IRQ_MASK_ADDR, {14'h0000, {2{a[2]}}});
      bus(1, FAULT_HWC_ADDR, {a[1:0], 14'h0001});
      undervoltageEvent <= 1'b1;
      highCurrentEvent <= 1'b1;
      @(posedge clk);
      undervoltageEvent <= 1'b0;
      highCurrentEvent <= 1'b0;
      @(posedge clk);
      chk(systemResetReq, a[1:0] == 2'b10, "reset request");
      repeat (3) @(posedge clk);
      chk(converterShutdown, a[1:0] == 2'b01, "shutdown");
      chk(irq, !a[2], "irq level");
      bus(0, IRQ_STATUS_ADDR, 0);
      chk(rd, 32'h0003, "status bits");
      bus(1, IRQ_STATUS_ADDR, 16'h0003);
      chk(irq, 0, "irq cleared");
      chk(converterShutdown, 0, "shutdown cleared");
    end
    $display("test undervoltage done");
    for (int f = 1; f < 3; f++)
    begin
      r = lfsr(r);
      bus(1, ON_CONFIG_ADDR, 16'h0003);
      // At 4MHz the boot code stays at or below 3Ch, under the 48h ceiling
      v = {11'h000, f[0] & r[4], r[3:0]};
      bootVoltageUpper <= v[4:0];
      bootFrequency <= f[1:0];
      bootLoad <= 1'b1;
      @(posedge clk);
      bootLoad <= 1'b0;
      @(posedge clk);
      bus(0, ON_CONFIG_ADDR, 0);
      chk(rd[6:0], {v[4:0], 2'b00}, "boot voltage");
      chk(switchingFrequency, f, "frequency output");
      bus(0, FREQ_ADDR, 0);
      chk(rd, f, "frequency readback");
    end
    $display("test boot load done");
    results();
  end
endmodule : buck1_hw_control_on_config_regs_bench

bind buck1_hw_control_on_config_regs buck1_hw_control_on_config_regs_monitor mon_i (.clk,
  .rst, .wbReq, .wbDatOut, .wbAck, .bootLoad, .undervoltageEvent, .highCurrentEvent,
  .convCtrl, .converterShutdown, .systemResetReq, .switchingFrequency, .irq);
`default_nettype wire
